// *** hdl/rtc_supervisor.sv ***
// rtc supervisor: watchdog, square wave, reset inputs, calibration, frequency test
`timescale 1ns/1ps
`default_nettype none
module rtc_supervisor
#(
   parameter int unsigned TR2_CYCLES = rtc_sup_pkg::TR2_CYC,
   parameter int unsigned TRHRZ_CYCLES = rtc_sup_pkg::TRHRZ_CYC,
   parameter int unsigned REC_CYCLES = rtc_sup_pkg::REC_CYC
) (
   input  wire logic                            clock,
   input  wire logic                            rst,
   input  wire logic [rtc_sup_pkg::ADDR_W-1:0]  address,
   input  wire logic                            read,
   input  wire logic                            write,
   input  wire logic [31:0]                     writedata,
   input  wire logic [3:0]                      byteenable,
   output logic [31:0]                          readdata,
   output logic                                 waitrequest,
   input  wire logic                            oscClkIn,
   input  wire logic                            powerFail,
   input  wire logic                            wdogKickInput,
   input  wire logic                            extResetInA_n,
   input  wire logic                            extResetInB_n,
   input  wire logic                            resetPinIn,
   output logic                                 resetPinOut,
   output logic                                 resetPinOe,
   input  wire logic                            irqFreqtestPinIn,
   output logic                                 irqFreqtestPinOut,
   output logic                                 irqFreqtestPinOe,
   output logic                                 squareWaveOut,
   output logic                                 squareWaveOe,
   output logic                                 secondTick
);
   import rtc_sup_pkg::*;

   typedef struct packed {
      logic [3:0]  sqRateSelect;
      logic        wdogTimeoutFlag;
      logic        alarmFlagEnable;
      logic        squareWaveEnable;
      logic        alarmBackupEnable;
      logic [4:0]  almMonth;
      logic [7:0]  wdReg;
      logic [1:0]  ctlWriteRead;
      logic        calSign;
      logic [4:0]  calMag;
      logic        oscillatorHalt;
      logic [6:0]  secLow;
      logic        freqTestBit;
      logic [2:0]  day;
      logic        oscPrev;
      logic [14:0] oscDiv;
      logic [15:0] secCnt;
      logic [5:0]  secInMin;
      logic [5:0]  calMin;
      logic        secondTick;
      logic        kickPrev;
      logic [16:0] wdPre;
      logic [4:0]  wdUnits;
      logic        irqWd;
      logic        wdIdle;
      logic [2:0]  aCnt;
      logic [22:0] bCnt;
      logic [22:0] recCnt;
      logic        busAck;
      logic [7:0]  rdata;
   } state_t;

   localparam logic [2:0] A_QUAL = 3'(TR1_CYC);
   localparam logic [22:0] B_QUAL = 23'(TR2_CYCLES);
   localparam logic [22:0] REL_LOAD = 23'(TRHRZ_CYCLES);
   localparam logic [22:0] REC_LOAD = 23'(REC_CYCLES);

   state_t s;
   state_t next_s;

   logic        oscRise;
   logic        kick;
   logic        busAccept;
   logic        wrEn;
   logic [18:0] regIdx;
   logic        idxOk;
   logic [7:0]  wdata8;
   logic [4:0]  wdMult;
   logic        wdSteer;
   logic [16:0] resTicks;
   logic        wdEnabled;
   logic        resTick;
   logic        wdTimeout;
   logic        wdRestart;
   logic        aQual;
   logic        bQual;
   logic        extHold;
   logic        corrSecond;
   logic [15:0] secLen;
   logic        testActive;
   logic [7:0]  regMux;

   // ***************************************************
   // decode and derived terms
   // ***************************************************
   assign regIdx = address[ADDR_W-1:2];
   assign idxOk = (address[1:0] == 2'h0);
   assign busAccept = (read | write) & s.busAck;
   assign wrEn = busAccept & write & byteenable[0] & idxOk & ~powerFail;
   assign wdata8 = writedata[7:0];
   assign oscRise = oscClkIn & ~s.oscPrev;
   assign kick = wdogKickInput ^ s.kickPrev;
   assign wdMult = s.wdReg[6:2];
   assign wdSteer = s.wdReg[WDOG_STEER_BIT];
   assign wdRestart = kick | (wrEn & regIdx == IDX_WDOG);
   assign wdEnabled = (wdMult != 5'h00) & ~s.wdIdle;
   assign resTick = oscRise & ~s.oscillatorHalt;
   assign aQual = (s.aCnt == A_QUAL);
   assign bQual = (s.bCnt == B_QUAL);
   assign extHold = aQual | bQual;

   always_comb begin
      unique case (s.wdReg[1:0])
         2'b00: resTicks = RES_16TH_TICKS;
         2'b01: resTicks = RES_QUART_TICKS;
         2'b10: resTicks = RES_ONE_TICKS;
         2'b11: resTicks = RES_FOUR_TICKS;
      endcase
   end

   // prescaler restarts with the period, so error stays under one unit
   assign wdTimeout = wdEnabled & ~wdRestart & resTick & (s.wdPre == resTicks - 17'h1)
      & (s.wdUnits == wdMult - 5'h1);

   // only the first 2N minutes, and never minutes 62 and 63
   assign corrSecond = (s.secInMin == 6'h00) & (s.calMin < {s.calMag, 1'b0})
      & (s.calMin < CAL_ELIG_MIN);
   assign secLen = corrSecond ? (s.calSign ? SEC_TICKS - CAL_SHORTEN
      : SEC_TICKS + CAL_LENGTHEN) : SEC_TICKS;

   // steered-to-irq watchdog with a nonzero register denies the test output
   assign testActive = ~s.oscillatorHalt & s.freqTestBit & ~s.alarmFlagEnable
      & (wdSteer | s.wdReg == 8'h00);

   always_comb begin
      regMux = 8'h00;
      if (idxOk) begin
         unique case (regIdx)
            IDX_FLAGS: regMux = {s.wdogTimeoutFlag, 3'h0, s.sqRateSelect};
            IDX_ALM_MONTH: regMux = {s.alarmFlagEnable, s.squareWaveEnable,
               s.alarmBackupEnable, s.almMonth};
            IDX_WDOG: regMux = s.wdReg;
            IDX_CONTROL: regMux = {s.ctlWriteRead, s.calSign, s.calMag};
            IDX_SECONDS: regMux = {s.oscillatorHalt, s.secLow};
            IDX_DAY: regMux = {1'b0, s.freqTestBit, 3'h0, s.day};
            default: regMux = 8'h00;
         endcase
      end
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      next_s = s;
      next_s.secondTick = 1'b0;
      next_s.oscPrev = oscClkIn;
      next_s.kickPrev = wdogKickInput;

      // bus slave: one wait cycle, read data latched before release
      next_s.busAck = (read | write) & ~s.busAck;
      if ((read & ~s.busAck) == 1'b1) begin
         next_s.rdata = regMux;
      end
      if (wrEn) begin
         unique case (regIdx)
            IDX_FLAGS: next_s.sqRateSelect = wdata8[3:0];
            IDX_ALM_MONTH: begin
               next_s.alarmFlagEnable = wdata8[ALM_ALARM_EN_BIT];
               next_s.squareWaveEnable = wdata8[ALM_SQ_EN_BIT];
               next_s.alarmBackupEnable = wdata8[ALM_BACKUP_EN_BIT];
               next_s.almMonth = wdata8[4:0];
            end
            IDX_WDOG: begin
               next_s.wdReg = wdata8;
               next_s.wdIdle = 1'b0;
               if (wdata8 == 8'h00) begin
                  next_s.irqWd = 1'b0;
               end
            end
            IDX_CONTROL: begin
               next_s.ctlWriteRead = wdata8[7:6];
               next_s.calSign = wdata8[CTL_SIGN_BIT];
               next_s.calMag = wdata8[4:0];
            end
            IDX_SECONDS: begin
               next_s.oscillatorHalt = wdata8[SEC_HALT_BIT];
               next_s.secLow = wdata8[6:0];
            end
            IDX_DAY: begin
               next_s.freqTestBit = wdata8[DAY_TEST_BIT];
               next_s.day = wdata8[2:0];
            end
            default: next_s.day = s.day;
         endcase
      end
      // flag clear first so a timeout in the same cycle survives
      if (busAccept & read & idxOk & regIdx == IDX_FLAGS) begin
         next_s.wdogTimeoutFlag = 1'b0;
      end

      // divider chain and calibrated seconds
      if (resTick) begin
         next_s.oscDiv = s.oscDiv + 15'h1;
         if (s.secCnt == secLen - 16'h1) begin
            next_s.secCnt = 16'h0000;
            next_s.secondTick = 1'b1;
            if (s.secInMin == SECS_PER_MIN - 6'h1) begin
               next_s.secInMin = 6'h00;
               next_s.calMin = s.calMin + 6'h1;
            end else begin
               next_s.secInMin = s.secInMin + 6'h1;
            end
         end else begin
            next_s.secCnt = s.secCnt + 16'h1;
         end
      end

      // watchdog
      if (wdRestart) begin
         next_s.wdPre = 17'h00000;
         next_s.wdUnits = 5'h00;
      end else if (wdEnabled & resTick) begin
         if (s.wdPre == resTicks - 17'h1) begin
            next_s.wdPre = 17'h00000;
            if (s.wdUnits == wdMult - 5'h1) begin
               next_s.wdUnits = 5'h00;
            end else begin
               next_s.wdUnits = s.wdUnits + 5'h1;
            end
         end else begin
            next_s.wdPre = s.wdPre + 17'h1;
         end
      end
      if (wdTimeout) begin
         next_s.wdogTimeoutFlag = 1'b1;
         if (wdSteer) begin
            next_s.recCnt = REC_LOAD;
            next_s.wdReg = WDOG_RESET;
            next_s.alarmFlagEnable = 1'b0;
            next_s.squareWaveEnable = 1'b0;
            next_s.alarmBackupEnable = 1'b0;
            next_s.freqTestBit = 1'b0;
         end else begin
            next_s.irqWd = 1'b1;
            next_s.wdIdle = 1'b1;
         end
      end

      // reset inputs, qualified by how long they stay low
      if (extResetInA_n) begin
         next_s.aCnt = 3'h0;
      end else if (!aQual) begin
         next_s.aCnt = s.aCnt + 3'h1;
      end
      if (extResetInB_n) begin
         next_s.bCnt = 23'h000000;
      end else if (!bQual) begin
         next_s.bCnt = s.bCnt + 23'h000001;
      end

      // reset output: held while a cause stands, then counted out
      if (powerFail) begin
         next_s.recCnt = REC_LOAD;
      end else if (extHold) begin
         next_s.recCnt = REL_LOAD;
      end else if (s.recCnt != 23'h000000 && !(wdTimeout & wdSteer)) begin
         next_s.recCnt = s.recCnt - 23'h000001;
      end

      // an external reset acts like a power cycle on the control bits, and also clears the alarm and square wave enables
      if (extHold) begin
         next_s.ctlWriteRead = 2'h0;
         next_s.freqTestBit = 1'b0;
         next_s.alarmFlagEnable = 1'b0;
         next_s.alarmBackupEnable = 1'b0;
         next_s.squareWaveEnable = 1'b0;
         next_s.wdReg = WDOG_RESET;
         next_s.irqWd = 1'b0;
         next_s.wdIdle = 1'b0;
      end
      // power-down keeps the alarm and square wave enables
      if (powerFail) begin
         next_s.wdReg = WDOG_RESET;
         next_s.irqWd = 1'b0;
         next_s.wdIdle = 1'b0;
         next_s.freqTestBit = 1'b0;
         next_s.ctlWriteRead = 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s <= '0;
         s.recCnt <= REC_LOAD;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign waitrequest = (read | write) & ~s.busAck;
   assign readdata = {24'h000000, s.rdata};
   assign resetPinOut = 1'b0;
   assign resetPinOe = (s.recCnt != 23'h000000);
   assign irqFreqtestPinOut = 1'b0;
   // test clock comes from the raw divider, so calibration never moves it
   assign irqFreqtestPinOe = s.irqWd | (testActive & s.oscDiv[TEST_DIV_BIT]);
   assign squareWaveOe = s.squareWaveEnable & (s.sqRateSelect != 4'h0);
   always_comb begin
      if (s.sqRateSelect == 4'h0) begin
         squareWaveOut = 1'b0;
      end else if (s.sqRateSelect == 4'h1) begin
         squareWaveOut = oscClkIn;
      end else begin
         // code n divides the oscillator by 2^n, which is divider bit n-1
         squareWaveOut = s.oscDiv[s.sqRateSelect - 4'h1];
      end
   end
   assign secondTick = s.secondTick;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_flag_read_clear: assert property ((busAccept && read && idxOk
      && regIdx == IDX_FLAGS && !wdTimeout) |=> !s.wdogTimeoutFlag)
      else $error("timeout flag not cleared");
   a_wd_irq_set: assert property ((wdTimeout && !wdSteer && !powerFail && !extHold)
      |=> (irqFreqtestPinOe && s.wdogTimeoutFlag)) else $error("irq timeout missing");
   a_wd_rst_pulse: assert property ((wdTimeout && wdSteer && !powerFail && !extHold)
      |=> (resetPinOe && s.wdReg == 8'h00 && !s.freqTestBit)) else $error("reset timeout bad");
   a_kick_restart: assert property (kick |=> (s.wdPre == 17'h0 && s.wdUnits == 5'h0))
      else $error("kick did not restart");
   a_irq_hold: assert property ((s.irqWd && !(wrEn && regIdx == IDX_WDOG) && !powerFail
      && !extHold) |=> s.irqWd) else $error("irq released early");
   a_rsta_latency: assert property ((!extResetInA_n)[*7] |-> resetPinOe)
      else $error("reset input a too slow");
   a_sqwave_off: assert property ((s.sqRateSelect == 4'h0 || !s.squareWaveEnable)
      |-> !squareWaveOe) else $error("square wave driven");
   a_test_denied: assert property ((!wdSteer && s.wdReg != 8'h00 && !s.irqWd)
      |-> !irqFreqtestPinOe) else $error("test output not denied");
   a_test_toggle: assert property ((testActive && !s.irqWd)
      |-> irqFreqtestPinOe == s.oscDiv[TEST_DIV_BIT]) else $error("test output wrong");
   a_pwr_clear: assert property (powerFail
      |=> (s.wdReg == 8'h00 && !s.freqTestBit && resetPinOe))
      else $error("power-down not applied");

   c_irq_timeout: cover property (wdTimeout && !wdSteer);
   c_rst_timeout: cover property (wdTimeout && wdSteer);
   c_ext_b_qual: cover property (bQual);
   c_test_running: cover property (testActive ##1 testActive);
endmodule
`default_nettype wire

// *** hdl/rtc_sup_pkg.sv ***
// constants shared by the rtc supervisor block
package rtc_sup_pkg;
   // ***************************************************
   // register indices (byte address = index * 4)
   // ***************************************************
   localparam int unsigned ADDR_W = 21;
   localparam logic [18:0] IDX_FLAGS = 19'h7fff0;
   localparam logic [18:0] IDX_ALM_MONTH = 19'h7fff6;
   localparam logic [18:0] IDX_WDOG = 19'h7fff7;
   localparam logic [18:0] IDX_CONTROL = 19'h7fff8;
   localparam logic [18:0] IDX_SECONDS = 19'h7fff9;
   localparam logic [18:0] IDX_DAY = 19'h7fffc;
   // ***************************************************
   // field positions and reset values
   // ***************************************************
   localparam int unsigned FLAGS_TIMEOUT_BIT = 7;
   localparam int unsigned WDOG_STEER_BIT = 7;
   localparam int unsigned ALM_ALARM_EN_BIT = 7;
   localparam int unsigned ALM_SQ_EN_BIT = 6;
   localparam int unsigned ALM_BACKUP_EN_BIT = 5;
   localparam int unsigned CTL_SIGN_BIT = 5;
   localparam int unsigned SEC_HALT_BIT = 7;
   localparam int unsigned DAY_TEST_BIT = 6;
   localparam logic [7:0] WDOG_RESET = 8'h00;
   // ***************************************************
   // oscillator divider chain, in oscillator cycles
   // ***************************************************
   localparam int unsigned OSC_HZ = 32768;
   localparam logic [16:0] RES_16TH_TICKS = 17'h00800;
   localparam logic [16:0] RES_QUART_TICKS = 17'h02000;
   localparam logic [16:0] RES_ONE_TICKS = 17'h08000;
   localparam logic [16:0] RES_FOUR_TICKS = 17'h20000;
   localparam logic [15:0] SEC_TICKS = 16'h8000;
   localparam logic [15:0] CAL_SHORTEN = 16'h0080;
   localparam logic [15:0] CAL_LENGTHEN = 16'h0100;
   localparam logic [5:0] SECS_PER_MIN = 6'h3c;
   localparam logic [5:0] CAL_ELIG_MIN = 6'h3e;
   localparam int unsigned TEST_DIV_BIT = 5;
   // ***************************************************
   // reset-input timing at the 100 MHz system clock
   // ***************************************************
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TR1_MIN_NS = 50;
   localparam int unsigned TR1_CYC = (TR1_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TR2_MIN_MS = 20;
   localparam int unsigned TR2_CYC = TR2_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned TRHRZ_MIN_MS = 40;
   localparam int unsigned TRHRZ_CYC = TRHRZ_MIN_MS * (CLK_HZ / 1000);
   localparam int unsigned REC_MIN_MS = 40;
   localparam int unsigned REC_CYC = REC_MIN_MS * (CLK_HZ / 1000);
endpackage

// *** verif/rtc_pin_env.sv ***
// far-side pin model: oscillator source and pulled-up open-drain pins
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_env (
   input  wire logic clock,
   input  wire logic resetPinOut,
   input  wire logic resetPinOe,
   input  wire logic irqFreqtestPinOut,
   input  wire logic irqFreqtestPinOe,
   output logic      oscClkIn,
   output logic      resetPinIn,
   output logic      irqFreqtestPinIn
);
   // ****************************************
   // oscillator, period 4 clocks
   // ****************************************
   // far faster than the crystal so that timeouts fit a short run
   logic [1:0] phase = 2'h0;
   always @(posedge clock) begin
      phase <= phase + 2'h1;
   end
   assign oscClkIn = phase[1];
   // ****************************************
   // open-drain pins with pull-ups
   // ****************************************
   assign resetPinIn = resetPinOe ? resetPinOut : 1'b1;
   assign irqFreqtestPinIn = irqFreqtestPinOe ? irqFreqtestPinOut : 1'b1;
endmodule
`default_nettype wire

// *** verif/rtc_supervisor_tb_top.sv ***
// self-checking testbench of the rtc supervisor
`timescale 1ns/1ps
`default_nettype none
module rtc_supervisor_tb_top;
   import rtc_sup_pkg::*;
   localparam int REC = 40;
   localparam int HRZ = 40;
   localparam int TR2 = 20;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = 32'h0;
   logic [31:0]       readdata;
   logic              waitrequest, oscClkIn, resetPinIn, irqFreqtestPinIn, secondTick;
   logic              powerFail = 1'b0;
   logic              wdogKickInput = 1'b0;
   logic              extResetInA_n = 1'b1;
   logic              extResetInB_n = 1'b1;
   logic              resetPinOut, resetPinOe, irqFreqtestPinOut, irqFreqtestPinOe;
   logic              squareWaveOut, squareWaveOe;
   int                n_errors = 0;
   int                checked = 0;

   always #5 clock = ~clock;

   rtc_supervisor #(.TR2_CYCLES(TR2), .TRHRZ_CYCLES(HRZ), .REC_CYCLES(REC)) i_dut (
      .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .oscClkIn(oscClkIn), .powerFail(powerFail),
      .wdogKickInput(wdogKickInput), .extResetInA_n(extResetInA_n),
      .extResetInB_n(extResetInB_n), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
      .resetPinOe(resetPinOe), .irqFreqtestPinIn(irqFreqtestPinIn),
      .irqFreqtestPinOut(irqFreqtestPinOut), .irqFreqtestPinOe(irqFreqtestPinOe),
      .squareWaveOut(squareWaveOut), .squareWaveOe(squareWaveOe), .secondTick(secondTick));

   rtc_pin_env i_env (
      .clock(clock), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
      .irqFreqtestPinOut(irqFreqtestPinOut), .irqFreqtestPinOe(irqFreqtestPinOe),
      .oscClkIn(oscClkIn), .resetPinIn(resetPinIn), .irqFreqtestPinIn(irqFreqtestPinIn));

   // ****************************************
   // helpers
   // ****************************************
   task automatic give_verdict();
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request stands until waitrequest is sampled low at a rising edge
   task automatic bus(input logic isWr, input logic [18:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clock);
      address <= {idx, 2'b00};
      write <= isWr;
      read <= !isWr;
      writedata <= {24'h0, d};
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [18:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [18:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(what, {24'h0, exp}, {24'h0, q});
   endtask

   function automatic logic pick(input int w);
      // pin levels behind the pull-ups, so the driven value is checked as well
      return (w == 0) ? !resetPinIn : (w == 1) ? !irqFreqtestPinIn : squareWaveOut;
   endfunction

   task automatic wait_for(input int w, input logic lvl, input int cap, output int n);
      n = 0;
      while (pick(w) !== lvl && n < cap) begin
         @(negedge clock);
         n++;
      end
   endtask

   task automatic edges(input int w, input int cyc, output int e);
      logic prev;
      e = 0;
      prev = pick(w);
      repeat (cyc) begin
         @(negedge clock);
         if (pick(w) === 1'b1 && prev === 1'b0) e++;
         prev = pick(w);
      end
   endtask

   task automatic ext_pulse(input logic useB, input int lowCyc, output int tOn,
                            output int tOff);
      tOn = -1;
      @(posedge clock);
      if (useB) extResetInB_n <= 1'b0;
      else extResetInA_n <= 1'b0;
      for (int i = 0; i < lowCyc; i++) begin
         @(negedge clock);
         if (resetPinOe === 1'b1 && tOn < 0) tOn = i;
      end
      @(posedge clock);
      extResetInA_n <= 1'b1;
      extResetInB_n <= 1'b1;
      wait_for(0, 1'b0, 300, tOff);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      int n;
      int e;
      int t;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      wait_for(0, 1'b0, 200, n);
      chk("recovery", 1, n >= REC - 2 && n <= REC + 2);
      rd_chk("wdog reset", IDX_WDOG, 8'h00);
      wr(IDX_CONTROL, 8'h3f);
      rd_chk("control", IDX_CONTROL, 8'h3f);
      rd_chk("unmapped", 19'h7fff5, 8'h00);
      wr(IDX_ALM_MONTH, 8'h40);
      for (int c = 0; c < 16; c++) begin
         wr(IDX_FLAGS, 8'(c));
         @(negedge clock);
         chk("sq enable", c != 0, squareWaveOe);
         if (c >= 1 && c <= 4) begin
            edges(2, 1600, e);
            t = (c == 1) ? 400 : (400 >> c);
            chk("sq rate", 1, e >= t - 1 && e <= t + 1);
         end
      end
      wr(IDX_ALM_MONTH, 8'h00);
      @(negedge clock);
      chk("sq off", 0, squareWaveOe);
      wr(IDX_FLAGS, 8'h00);
      // two sixteenths steered to the interrupt pin, kept alive four times
      wr(IDX_WDOG, 8'h08);
      for (int k = 0; k < 4; k++) begin
         repeat (4000) @(posedge clock);
         if (k == 2) wr(IDX_WDOG, 8'h08);
         else wdogKickInput <= !wdogKickInput;
         @(negedge clock);
         chk("no early irq", 0, irqFreqtestPinOe);
      end
      wait_for(1, 1'b1, 30000, n);
      chk("wdog period", 1, n >= 8100 && n <= 24700);
      rd_chk("flag set", IDX_FLAGS, 8'h80);
      rd_chk("flag cleared", IDX_FLAGS, 8'h00);
      wr(IDX_DAY, 8'h40);
      edges(1, 400, e);
      chk("irq over test", 0, e);
      chk("irq held", 1, irqFreqtestPinOe);
      wr(IDX_WDOG, 8'h00);
      edges(1, 1600, e);
      chk("test toggles", 1, e >= 5 && e <= 7);
      wr(IDX_CONTROL, 8'h1f);
      edges(1, 1600, e);
      chk("test vs cal", 1, e >= 5 && e <= 7);
      wr(IDX_ALM_MONTH, 8'h80);
      edges(1, 1600, e);
      chk("test alarm off", 0, e);
      wr(IDX_ALM_MONTH, 8'h00);
      wr(IDX_SECONDS, 8'h80);
      edges(1, 1600, e);
      chk("test halted", 0, e);
      wr(IDX_SECONDS, 8'h00);
      // one sixteenth steered to the reset pin
      wr(IDX_ALM_MONTH, 8'he0);
      wr(IDX_WDOG, 8'h84);
      wait_for(0, 1'b1, 20000, n);
      chk("reset pulse start", 1, n <= 16500);
      wait_for(0, 1'b0, 200, n);
      chk("reset pulse width", 1, n >= REC - 2 && n <= REC + 2);
      rd_chk("flag steer", IDX_FLAGS, 8'h80);
      rd_chk("wdog cleared", IDX_WDOG, 8'h00);
      rd_chk("alarm cleared", IDX_ALM_MONTH, 8'h00);
      rd_chk("test bit cleared", IDX_DAY, 8'h00);
      // external reset inputs
      ext_pulse(1'b0, 3, t, n);
      chk("short a", 32'hffffffff, t);
      wr(IDX_WDOG, 8'h08);
      ext_pulse(1'b0, 12, t, n);
      chk("a delay", 1, t >= 4 && t <= 19);
      chk("a release", 1, n >= HRZ - 2 && n <= HRZ + 3);
      rd_chk("a clears wdog", IDX_WDOG, 8'h00);
      ext_pulse(1'b1, TR2 - 5, t, n);
      chk("short b", 32'hffffffff, t);
      ext_pulse(1'b1, 3 * TR2, t, n);
      chk("b delay", 1, t >= TR2 - 1 && t <= 2 * TR2);
      chk("b release", 1, n >= HRZ - 2 && n <= HRZ + 3);
      // supply failure
      wr(IDX_WDOG, 8'h08);
      wr(IDX_DAY, 8'h40);
      @(posedge clock);
      powerFail <= 1'b1;
      repeat (10) @(posedge clock);
      powerFail <= 1'b0;
      @(negedge clock);
      chk("pf reset", 1, resetPinOe);
      wait_for(0, 1'b0, 200, n);
      chk("pf recovery", 1, n >= REC - 2 && n <= REC + 2);
      rd_chk("pf wdog", IDX_WDOG, 8'h00);
      rd_chk("pf test bit", IDX_DAY, 8'h00);
      give_verdict();
   end

   initial begin
      repeat (90000) @(posedge clock);
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
